// [pew_host.sv]
`timescale 1ns/10ps
`include "pew_map.svh"
module pew_host #(
  parameter int unsigned PROG_CYC  = `PEW_PROG_CYC,
  parameter int unsigned ERASE_CYC = `PEW_ERASE_CYC,
  parameter int unsigned PWRUP_W   = `PEW_PWRUP_W_CYC,
  parameter int unsigned GAP_MAX   = `PEW_GAP_MAX_CYC,
  parameter int unsigned PWRUP_R   = `PEW_PWRUP_R_CYC,
  parameter logic [14:0] ERASE_ADDR [6] = '{15'h0000, 15'h0000, 15'h0000,
                                            15'h0000, 15'h0000, 15'h0000},
  parameter logic [7:0]  ERASE_DATA [6] = '{8'h00, 8'h00, 8'h00,
                                            8'h00, 8'h00, 8'h00}
) (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_reset_n,
  // Command side
  input  wire logic               i_load_valid,
  input  wire pew_pkg::pew_load_t i_load,
  input  wire logic               i_load_last,
  input  wire logic               i_read_valid,
  input  wire logic [14:0]        i_read_addr,
  input  wire logic               i_erase_start,
  output logic                    o_load_ready,
  output logic                    o_read_ready,
  output logic                    o_erase_ready,
  output logic                    o_read_done,
  output logic [7:0]              o_read_data,
  output logic                    o_busy,
  output logic                    o_page_error,
  // Memory pins
  output pew_pkg::pew_strobe_t    o_strobe,
  output logic [14:0]             o_addr,
  output logic [7:0]              o_dq_out,
  output logic                    o_dq_oe_n,
  input  wire logic [7:0]         i_dq_in
);
  localparam int unsigned GAP_MIN = `PEW_GAP_MIN_CYC;
  localparam int unsigned STRB    = `PEW_STROBE_CYC;
  localparam int unsigned SETUP   = `PEW_CE_SETUP_CYC;
  localparam int unsigned NSTEP   = `PEW_ERASE_STEPS;

  pew_pkg::pew_state_t state_q;
  logic [31:0] cnt_q;
  logic [31:0] gap_q;
  logic        pwr_r_ok_q;
  logic        loading_q;
  logic        erase_q;
  logic [2:0]  step_q;
  logic        last_q;
  logic [8:0]  page_q;
  logic [7:0]  sync1_q;
  logic [7:0]  sync2_q;
  logic [7:0]  sync3_q;
  logic [7:0]  dq_hold_q;

  function automatic logic [8:0] page_of(input logic [14:0] a);
    page_of = a[14:`PEW_PAGE_LSB];
  endfunction

  wire idle     = state_q == pew_pkg::PEW_IDLE;
  // Loads only at least GAP_MIN after the previous one, and not at the
  // expiry edge, where the page closes and a load would be lost
  wire gap_open = state_q == pew_pkg::PEW_GAP && gap_q >= GAP_MIN &&
                  gap_q < GAP_MAX;
  assign o_load_ready  = (idle || gap_open) && !erase_q;
  assign o_read_ready  = idle && pwr_r_ok_q;
  assign o_erase_ready = idle && !loading_q;
  assign o_busy        = !idle;

  // Three-stage sync of the returning data bus
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      sync3_q <= 8'h00;
      dq_hold_q <= 8'h00;
    end else begin
      sync1_q <= i_dq_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      // Bus value counts only once the last two stages agree
      if (sync2_q == sync3_q)
        dq_hold_q <= sync3_q;
    end
  end

  // Main sequencer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q      <= pew_pkg::PEW_PWRUP;
      cnt_q        <= 32'h0000_0000;
      gap_q        <= 32'h0000_0000;
      pwr_r_ok_q   <= 1'b0;
      loading_q    <= 1'b0;
      erase_q      <= 1'b0;
      step_q       <= 3'h0;
      last_q       <= 1'b0;
      page_q       <= 9'h000;
      o_strobe     <= 3'h7;
      o_addr       <= 15'h0000;
      o_dq_out     <= 8'h00;
      o_dq_oe_n    <= 1'b1;
      o_read_done  <= 1'b0;
      o_read_data  <= 8'h00;
      o_page_error <= 1'b0;
    end else begin
      o_read_done  <= 1'b0;
      o_page_error <= 1'b0;
      cnt_q <= cnt_q + 32'h0000_0001;
      if (state_q == pew_pkg::PEW_GAP)
        gap_q <= gap_q + 32'h0000_0001;
      unique case (state_q)
        pew_pkg::PEW_PWRUP: begin
          if (cnt_q >= PWRUP_R)
            pwr_r_ok_q <= 1'b1;
          if (cnt_q >= PWRUP_W) begin
            state_q <= pew_pkg::PEW_IDLE;
          end
        end
        pew_pkg::PEW_IDLE, pew_pkg::PEW_GAP: begin
          if (state_q == pew_pkg::PEW_GAP && gap_q >= GAP_MAX) begin
            // Gap expired: device starts programming on its own
            state_q   <= pew_pkg::PEW_PROG;
            loading_q <= 1'b0;
            cnt_q     <= 32'h0000_0000;
          end else if (o_erase_ready && i_erase_start) begin
            erase_q <= 1'b1;
            step_q  <= 3'h0;
            state_q <= pew_pkg::PEW_SETUP;
            o_addr  <= ERASE_ADDR[0];
            o_dq_out <= ERASE_DATA[0];
            o_strobe <= 3'h3; // CE low first
            cnt_q   <= 32'h0000_0000;
          end else if (erase_q && state_q == pew_pkg::PEW_GAP) begin
            if (gap_q >= GAP_MIN) begin
              state_q  <= pew_pkg::PEW_SETUP;
              o_addr   <= ERASE_ADDR[step_q];
              o_dq_out <= ERASE_DATA[step_q];
              o_strobe <= 3'h3;
              cnt_q    <= 32'h0000_0000;
            end
          end else if (o_load_ready && i_load_valid) begin
            // Page address locked on first load of a page
            if (loading_q && page_of(i_load.addr) != page_q) begin
              o_page_error <= 1'b1;
            end else begin
              page_q   <= page_of(i_load.addr);
              loading_q <= 1'b1;
              last_q   <= i_load_last;
              o_addr   <= i_load.addr;
              o_dq_out <= i_load.data;
              o_strobe <= 3'h3;
              state_q  <= pew_pkg::PEW_SETUP;
              cnt_q    <= 32'h0000_0000;
            end
          end else if (idle && o_read_ready && i_read_valid) begin
            o_addr   <= i_read_addr;
            o_strobe <= 3'h1;
            state_q  <= pew_pkg::PEW_READ;
            cnt_q    <= 32'h0000_0000;
          end
        end
        pew_pkg::PEW_SETUP: begin
          // Drive bus while OE high, CE low, then drop WE
          o_dq_oe_n <= 1'b0;
          if (cnt_q >= SETUP) begin
            o_strobe <= 3'h2;
            state_q  <= pew_pkg::PEW_STRB;
            cnt_q    <= 32'h0000_0000;
          end
        end
        pew_pkg::PEW_STRB: begin
          if (cnt_q >= STRB) begin
            // WE rises first, data latched; OE stays high
            o_strobe <= 3'h3;
            state_q  <= pew_pkg::PEW_GAP;
            gap_q    <= 32'h0000_0000;
            cnt_q    <= 32'h0000_0000;
            if (erase_q) begin
              step_q <= step_q + 3'h1;
              if (step_q == 3'(NSTEP - 1)) begin
                state_q <= pew_pkg::PEW_PROG;
              end
            end else if (last_q) begin
              state_q   <= pew_pkg::PEW_PROG;
              loading_q <= 1'b0;
            end
          end
        end
        pew_pkg::PEW_PROG: begin
          // Pins parked, no loads until the self-timed cycle ends
          o_strobe  <= 3'h7;
          o_dq_oe_n <= 1'b1;
          // Last-load wait uses gap time too; full bound is safe
          if (erase_q ? cnt_q >= ERASE_CYC : cnt_q >= PROG_CYC) begin
            state_q <= pew_pkg::PEW_IDLE;
            erase_q <= 1'b0;
            cnt_q   <= 32'h0000_0000;
          end
        end
        pew_pkg::PEW_READ: begin
          o_dq_oe_n <= 1'b1;
          // Allow access time plus three sync stages
          if (cnt_q >= STRB + 3) begin
            o_read_data <= dq_hold_q;
            o_read_done <= 1'b1;
            o_strobe    <= 3'h7;
            state_q     <= pew_pkg::PEW_IDLE;
          end
        end
        default: state_q <= pew_pkg::PEW_IDLE;
      endcase
    end
  end
endmodule

// [pew_host_monitor.sv]
`timescale 1ns/10ps
module pew_host_monitor #(
  parameter int unsigned PWRUP_W = 20,
  parameter int unsigned PWRUP_R = 10
) (
  // Clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_reset_n,
  // Watched ports
  input wire logic                 i_load_valid,
  input wire logic                 i_read_valid,
  input wire logic                 o_load_ready,
  input wire logic                 o_read_ready,
  input wire logic                 o_erase_ready,
  input wire logic                 o_read_done,
  input wire logic                 o_page_error,
  input wire pew_pkg::pew_strobe_t o_strobe,
  input wire logic                 o_dq_oe_n
);
  int unsigned up_q;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      up_q <= 0;
    end else if (up_q < PWRUP_W) begin
      up_q <= up_q + 1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  write_gate_a: assert property (
    !o_strobe.we_n |-> o_strobe.oe_n && !o_strobe.ce_n) else $error("gate");
  bus_turn_a: assert property (
    !o_strobe.oe_n |-> o_dq_oe_n) else $error("bus clash");
  load_start_a: assert property (
    o_load_ready && i_load_valid |=> o_strobe == 3'h3) else $error("load");
  load_gap_a: assert property (
    $rose(o_strobe.we_n) |-> o_strobe.we_n [*5]) else $error("gap short");
  read_done_a: assert property (
    o_read_ready && i_read_valid |-> ##10 o_read_done) else $error("read");
  page_pulse_a: assert property (
    o_page_error |-> $past(i_load_valid) ##1 !o_page_error) else $error("pe");
  pwrup_write_a: assert property (
    up_q + 1 < PWRUP_W |-> !o_load_ready && !o_erase_ready) else $error("pw");
  pwrup_read_a: assert property (
    up_q + 1 < PWRUP_R |-> !o_read_ready) else $error("pr");
endmodule
bind pew_host pew_host_monitor #(.PWRUP_W(PWRUP_W), .PWRUP_R(PWRUP_R))
  pew_host_monitor_i (
    .i_clk         (i_clk),
    .i_reset_n     (i_reset_n),
    .i_load_valid  (i_load_valid),
    .i_read_valid  (i_read_valid),
    .o_load_ready  (o_load_ready),
    .o_read_ready  (o_read_ready),
    .o_erase_ready (o_erase_ready),
    .o_read_done   (o_read_done),
    .o_page_error  (o_page_error),
    .o_strobe      (o_strobe),
    .o_dq_oe_n     (o_dq_oe_n)
  );

// [pew_map.svh]
`ifndef PEW_MAP_SVH
`define PEW_MAP_SVH
`define PEW_CLK_MHZ            25
`define PEW_LOAD_GAP_MIN_NS    200
`define PEW_LOAD_GAP_MAX_US    150
`define PEW_PROG_MAX_MS        10
`define PEW_ERASE_MAX_MS       20
`define PEW_PWRUP_WRITE_MS     5
`define PEW_PWRUP_READ_US      100
`define PEW_STROBE_NS          200
`define PEW_CE_SETUP_US        1
`define PEW_GAP_MIN_CYC  ((`PEW_LOAD_GAP_MIN_NS*`PEW_CLK_MHZ+999)/1000)
`define PEW_GAP_MAX_CYC  (`PEW_LOAD_GAP_MAX_US*`PEW_CLK_MHZ)
`define PEW_PROG_CYC     (`PEW_PROG_MAX_MS*1000*`PEW_CLK_MHZ)
`define PEW_ERASE_CYC    (`PEW_ERASE_MAX_MS*1000*`PEW_CLK_MHZ)
`define PEW_PWRUP_W_CYC  (`PEW_PWRUP_WRITE_MS*1000*`PEW_CLK_MHZ)
`define PEW_PWRUP_R_CYC  (`PEW_PWRUP_READ_US*`PEW_CLK_MHZ)
`define PEW_STROBE_CYC   ((`PEW_STROBE_NS*`PEW_CLK_MHZ+999)/1000)
`define PEW_CE_SETUP_CYC (`PEW_CE_SETUP_US*`PEW_CLK_MHZ)
`define PEW_ERASE_STEPS  6
`define PEW_PAGE_LSB     6
`endif

// [pew_mem_model.sv]
`timescale 1ns/10ps
module pew_mem_model (
  // Pins from host
  input  wire pew_pkg::pew_strobe_t i_strobe,
  input  wire logic [14:0]          i_addr,
  input  wire logic [7:0]           i_dq,
  // Pins to host
  output logic [7:0]                o_dq
);
  logic [7:0] mem [32768];
  logic [7:0] last_q;
  int         hits;
  wire        rd = !i_strobe.ce_n && !i_strobe.oe_n && i_strobe.we_n;
  initial begin
    foreach (mem[k]) mem[k] = 8'h00;
    last_q = 8'h00;
    hits = 0;
  end
  // No pull on the bus: released lines show the inverse
  assign o_dq = rd ? mem[i_addr] : ~last_q;
  always @(posedge i_strobe.oe_n) begin
    last_q = mem[i_addr];
  end
  always @(posedge i_strobe.we_n) begin
    if (!i_strobe.ce_n && i_strobe.oe_n) begin
      mem[i_addr] = i_dq;
      hits = (i_addr == 15'h0000 && i_dq == 8'h00) ? hits + 1 : 0;
      if (hits == 6) begin
        // Sixth consecutive write of 00 to 0000 sets the whole array to FF
        foreach (mem[k]) mem[k] = 8'hFF;
        hits = 0;
      end
    end
  end
endmodule

// [pew_pkg.sv]
package pew_pkg;
  typedef enum logic [6:0] {
    PEW_IDLE  = 7'h01,
    PEW_SETUP = 7'h02,
    PEW_STRB  = 7'h04,
    PEW_GAP   = 7'h08,
    PEW_PROG  = 7'h10,
    PEW_READ  = 7'h20,
    PEW_PWRUP = 7'h40
  } pew_state_t;
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  data;
  } pew_load_t;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
  } pew_strobe_t;
endpackage

// [tb.sv]
`timescale 1ns/10ps
module tb;
  logic                 i_clk, i_reset_n, i_load_valid, i_load_last;
  logic                 i_read_valid, i_erase_start, o_load_ready;
  logic                 o_read_ready, o_erase_ready, o_read_done, o_busy;
  logic                 o_page_error, o_dq_oe_n;
  logic [14:0]          i_read_addr, o_addr;
  logic [7:0]           o_read_data, o_dq_out, mem_dq, i_dq_in;
  pew_pkg::pew_load_t   i_load;
  pew_pkg::pew_strobe_t o_strobe;
  int                   n_mismatch = 0, checked = 0, cyc = 0;
  assign i_dq_in = o_dq_oe_n ? mem_dq : o_dq_out;
  pew_host #(.PROG_CYC(50), .ERASE_CYC(80), .PWRUP_W(20), .GAP_MAX(40),
    .PWRUP_R(10)) pew_host_i (
    .i_clk         (i_clk),
    .i_reset_n     (i_reset_n),
    .i_load_valid  (i_load_valid),
    .i_load        (i_load),
    .i_load_last   (i_load_last),
    .i_read_valid  (i_read_valid),
    .i_read_addr   (i_read_addr),
    .i_erase_start (i_erase_start),
    .o_load_ready  (o_load_ready),
    .o_read_ready  (o_read_ready),
    .o_erase_ready (o_erase_ready),
    .o_read_done   (o_read_done),
    .o_read_data   (o_read_data),
    .o_busy        (o_busy),
    .o_page_error  (o_page_error),
    .o_strobe      (o_strobe),
    .o_addr        (o_addr),
    .o_dq_out      (o_dq_out),
    .o_dq_oe_n     (o_dq_oe_n),
    .i_dq_in       (i_dq_in)
  );
  pew_mem_model pew_mem_model_i (.i_strobe(o_strobe), .i_addr(o_addr),
    .i_dq(o_dq_out), .o_dq(mem_dq));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // Whole run needs about 800 cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle();
    repeat (3) @(posedge i_clk);
    @(posedge i_clk iff !o_busy);
  endtask
  task automatic load(input logic [14:0] a, input logic [7:0] d,
                      input logic l);
    @(posedge i_clk iff o_load_ready);
    i_load_valid <= 1'b1;
    i_load <= '{addr: a, data: d};
    i_load_last <= l;
    @(posedge i_clk iff o_load_ready);
    i_load_valid <= 1'b0;
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    @(posedge i_clk iff o_read_ready);
    i_read_valid <= 1'b1;
    i_read_addr <= a;
    @(posedge i_clk);
    i_read_valid <= 1'b0;
    @(posedge i_clk iff o_read_done);
    #1 chk(o_read_data, e);
  endtask
  task automatic t_pwrup();
    @(posedge i_clk);
    #1 chk({4'h0, o_read_ready, o_erase_ready, o_load_ready, o_busy},
           8'h01);
    idle();
    #1 chk({5'h00, o_read_ready, o_erase_ready, o_load_ready},
           8'h07);
    $display("power-up test done");
  endtask
  task automatic t_page();
    load(15'h0041, 8'hA5, 1'b0);
    load(15'h0042, 8'h5A, 1'b0);
    load(15'h0043, 8'h3C, 1'b1);
    idle();
    rd(15'h0041, 8'hA5);
    rd(15'h0043, 8'h3C);
    $display("page write test done");
  endtask
  task automatic t_perr();
    load(15'h0100, 8'h11, 1'b0);
    load(15'h0200, 8'h99, 1'b0);
    #1 chk({7'h00, o_page_error}, 8'h01);
    chk({6'h00, o_erase_ready, o_read_ready}, 8'h00);
    load(15'h0101, 8'h22, 1'b1);
    idle();
    rd(15'h0101, 8'h22);
    rd(15'h0200, 8'h00);
    $display("page error test done");
  endtask
  task automatic t_gap();
    load(15'h0300, 8'h77, 1'b0);
    idle();
    rd(15'h0300, 8'h77);
    $display("gap close test done");
  endtask
  task automatic t_erase();
    @(posedge i_clk iff o_erase_ready);
    i_erase_start <= 1'b1;
    @(posedge i_clk);
    i_erase_start <= 1'b0;
    repeat (20) @(posedge i_clk);
    #1 chk({7'h00, o_load_ready}, 8'h00);
    idle();
    rd(15'h0042, 8'hFF);
    $display("erase test done");
  endtask
  initial begin
    {i_load_valid, i_load_last, i_read_valid, i_erase_start} = 4'h0;
    i_load = '0;
    i_read_addr = 15'h0000;
    i_reset_n = 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_pwrup();
    t_page();
    t_perr();
    t_gap();
    t_erase();
    give_verdict();
  end
endmodule
